// File: hw/bcd_adder_unit.sv
// Purpose: decimal add unit for the controller instruction sequencer
// Assumes: sequencer supplies operands and writes the result words back
// Notes: one-cycle request, answer two edges later
`timescale 1ns/1ps
`include "bcd_adder_defines.svh"
// Summary of operation
// (RULE1) Code 404 adds two 4-digit decimal words
// (RULE2) Code 405 adds two 8-digit double words
// (RULE3) Code 406 adds single words plus carry
// (RULE4) Code 407 adds double words plus carry
// (RULE5) Single: error when either word has bad digit
// (RULE6) Double: error when any nibble is bad
// (RULE7) Zero flag set when written sum is zero
// (RULE8) Carry flag set on decimal overflow
// (RULE9) Low digits first word, high digits next
// (RULE10) Code 041 clears the carry flag
// (RULE11) Sequencer requests only when condition true
// (RULE12) Error leaves destination, zero and carry flags unchanged
// (RULE13) Digit sums above nine get six added
module bcd_adder_unit #(
  parameter int DIGITS_SINGLE = 4,
  parameter int DIGITS_DOUBLE = 8
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic op_valid,
  input wire bcd_adder_pkg::opcode_type op_code,
  input wire bcd_adder_pkg::word_type first_summand_lo,
  input wire bcd_adder_pkg::word_type first_summand_hi,
  input wire bcd_adder_pkg::word_type second_summand_lo,
  input wire bcd_adder_pkg::word_type second_summand_hi,
  output logic busy,
  output logic done,
  output logic result_write,
  output logic result_double,
  output bcd_adder_pkg::word_type result_lo,
  output bcd_adder_pkg::word_type result_hi,
  output logic invalid_digit_flag,
  output logic zero_result_flag,
  output logic carry_flag
);
  import bcd_adder_pkg::*;

  localparam int WIDE = DIGITS_DOUBLE * `DIGIT_W;
  localparam int NARROW = DIGITS_SINGLE * `DIGIT_W;

  function automatic logic has_bad_digit(input logic [WIDE-1:0] v, input int digits);
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < DIGITS_DOUBLE; i++) begin
      if (i < digits && v[i*`DIGIT_W +: `DIGIT_W] > `DIGIT_MAX) begin
        bad = 1'b1;
      end
    end
    return bad;
  endfunction

  function automatic logic is_add(input opcode_type c);
    return c == `OPC_ADD_SINGLE || c == `OPC_ADD_DOUBLE || c == `OPC_ADD_SINGLE_CI || c == `OPC_ADD_DOUBLE_CI;
  endfunction

  function automatic logic is_double(input opcode_type c);
    return c == `OPC_ADD_DOUBLE || c == `OPC_ADD_DOUBLE_CI;
  endfunction

  function automatic logic uses_carry_in(input opcode_type c);
    return c == `OPC_ADD_SINGLE_CI || c == `OPC_ADD_DOUBLE_CI;
  endfunction

  function automatic logic is_carry_clear(input opcode_type c);
    return c == `OPC_CARRY_CLEAR;
  endfunction

  state_type state_r;
  logic [WIDE-1:0] a_r;
  logic [WIDE-1:0] b_r;
  logic double_r;
  logic use_carry_r;
  logic [WIDE-1:0] sum;
  logic [DIGITS_DOUBLE:0] chain;
  logic [WIDE-1:0] sum_masked;
  logic carry_nxt;
  logic bad_nxt;

  // Operand capture; the request only arrives under a true condition
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      a_r <= '0;
      b_r <= '0;
      double_r <= `FLAG_RESET;
      use_carry_r <= `FLAG_RESET;
    end else if (state_r == ST_IDLE && op_valid && is_add(op_code)) begin // see (RULE11)
      double_r <= is_double(op_code); // see (RULE2) see (RULE4)
      use_carry_r <= uses_carry_in(op_code); // see (RULE3) see (RULE4)
      if (is_double(op_code)) begin
        a_r <= {first_summand_hi, first_summand_lo};
        b_r <= {second_summand_hi, second_summand_lo};
      end else begin
        a_r <= {{(WIDE-NARROW){1'b0}}, first_summand_lo};
        b_r <= {{(WIDE-NARROW){1'b0}}, second_summand_lo};
      end
    end
  end

  a_operand_hold: assert property (@(posedge core_clk) disable iff (!arst_n) // see (RULE2)
    state_r != ST_IDLE
    |=> $stable(a_r) && $stable(b_r))
    else $error("operands changed during add");

  a_unknown_ignored: assert property (@(posedge core_clk) disable iff (!arst_n) // see (RULE1)
    (state_r == ST_IDLE && op_valid && !is_add(op_code))
    |=> state_r == ST_IDLE)
    else $error("unknown code started an add");

  bcd_digit_chain #(
    .DIGITS(DIGITS_DOUBLE)
  ) bcd_digit_chain_i (
    .first_summand(a_r),
    .second_summand(b_r),
    .carry_in(use_carry_r & carry_flag), // see (RULE3) see (RULE4)
    .sum(sum),
    .carry_chain(chain)
  );

  a_carry_in_used: assert property (@(posedge core_clk) disable iff (!arst_n) // see (RULE4)
    (state_r == ST_CALC && use_carry_r && carry_flag)
    |-> chain[0])
    else $error("carry flag not used as carry in");

  // Overflow taken at the digit width of the operation
  always_comb begin
    bad_nxt = double_r ? has_bad_digit(a_r, DIGITS_DOUBLE) | has_bad_digit(b_r, DIGITS_DOUBLE) // see (RULE6)
                       : has_bad_digit(a_r, DIGITS_SINGLE) | has_bad_digit(b_r, DIGITS_SINGLE); // see (RULE5)
    carry_nxt = double_r ? chain[DIGITS_DOUBLE] : chain[DIGITS_SINGLE]; // see (RULE8)
    sum_masked = double_r ? sum : {{(WIDE-NARROW){1'b0}}, sum[NARROW-1:0]}; // see (RULE1)
  end

  a_single_addend_error: assert property (@(posedge core_clk) disable iff (!arst_n) // see (RULE5)
    (state_r == ST_CALC && !double_r && b_r[`DIGIT_W-1:0] > `DIGIT_MAX)
    |=> invalid_digit_flag)
    else $error("bad addend digit missed");

  a_double_augend_error: assert property (@(posedge core_clk) disable iff (!arst_n) // see (RULE6)
    (state_r == ST_CALC && double_r && a_r[WIDE-1 -: `DIGIT_W] > `DIGIT_MAX)
    |=> invalid_digit_flag)
    else $error("high augend bad digit missed");

  // Sequencing
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (op_valid && is_add(op_code)) begin
            state_r <= ST_CALC;
          end
        end
        ST_CALC: begin
          state_r <= ST_DONE;
        end
        ST_DONE: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  a_calc_to_done: assert property (@(posedge core_clk) disable iff (!arst_n) // see (RULE1)
    state_r == ST_CALC
    |=> state_r == ST_DONE)
    else $error("add did not finish");

  a_done_pulse: assert property (@(posedge core_clk) disable iff (!arst_n) // see (RULE1)
    done
    |=> !done)
    else $error("done longer than one cycle");

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= `FLAG_RESET;
    end else begin
      busy <= (state_r == ST_IDLE && op_valid && is_add(op_code)) || state_r == ST_CALC;
    end
  end

  // Result words and write strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      done <= `FLAG_RESET;
      result_write <= `FLAG_RESET;
      result_double <= `FLAG_RESET;
      result_lo <= '0;
      result_hi <= '0;
    end else begin
      done <= state_r == ST_CALC;
      result_write <= state_r == ST_CALC && !bad_nxt; // see (RULE12)
      if (state_r == ST_CALC) begin
        result_double <= double_r;
        if (!bad_nxt) begin // see (RULE12)
          result_lo <= sum_masked[`WORD_W-1:0]; // see (RULE9)
          result_hi <= sum_masked[WIDE-1:`WORD_W]; // see (RULE9)
        end
      end
    end
  end

  a_double_write: assert property (@(posedge core_clk) disable iff (!arst_n) // see (RULE9)
    (state_r == ST_CALC && double_r && !bad_nxt)
    |=> result_write && result_double)
    else $error("double result not written as two words");

  a_write_pulse: assert property (@(posedge core_clk) disable iff (!arst_n) // see (RULE12)
    result_write
    |=> !result_write)
    else $error("write strobe longer than one cycle");

  a_write_with_done: assert property (@(posedge core_clk) disable iff (!arst_n) // see (RULE12)
    result_write
    |-> done)
    else $error("write strobe without done");

  a_result_hold: assert property (@(posedge core_clk) disable iff (!arst_n) // see (RULE12)
    !(state_r == ST_CALC && !bad_nxt)
    |=> $stable(result_lo) && $stable(result_hi))
    else $error("result words changed without a valid add");

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      invalid_digit_flag <= `FLAG_RESET;
    end else if (state_r == ST_CALC) begin
      invalid_digit_flag <= bad_nxt; // see (RULE5) see (RULE6)
    end
  end

  a_valid_clears: assert property (@(posedge core_clk) disable iff (!arst_n) // see (RULE6)
    (state_r == ST_CALC && !bad_nxt)
    |=> !invalid_digit_flag)
    else $error("error flag kept after valid add");

  a_flag_hold: assert property (@(posedge core_clk) disable iff (!arst_n) // see (RULE5)
    state_r != ST_CALC
    |=> $stable(invalid_digit_flag))
    else $error("error flag changed outside an add");

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      zero_result_flag <= `FLAG_RESET;
    end else if (state_r == ST_CALC && !bad_nxt) begin // see (RULE12)
      zero_result_flag <= sum_masked == '0; // see (RULE7)
    end
  end

  a_zero_hold: assert property (@(posedge core_clk) disable iff (!arst_n) // see (RULE7)
    state_r != ST_CALC
    |=> $stable(zero_result_flag))
    else $error("zero flag changed outside an add");

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      carry_flag <= `FLAG_RESET;
    end else if (state_r == ST_IDLE && op_valid && is_carry_clear(op_code)) begin
      carry_flag <= `FLAG_RESET; // see (RULE10)
    end else if (state_r == ST_CALC && !bad_nxt) begin
      carry_flag <= carry_nxt; // see (RULE8)
    end
  end

  a_clear_no_busy: assert property (@(posedge core_clk) disable iff (!arst_n) // see (RULE10)
    (state_r == ST_IDLE && op_valid && is_carry_clear(op_code))
    |=> !busy)
    else $error("carry clear started an add");

  a_carry_hold: assert property (@(posedge core_clk) disable iff (!arst_n) // see (RULE8)
    (state_r != ST_CALC && !(state_r == ST_IDLE && op_valid && is_carry_clear(op_code)))
    |=> $stable(carry_flag))
    else $error("carry flag changed without cause");

  a_carry_clear: assert property (@(posedge core_clk) disable iff (!arst_n) // see (RULE10)
    (state_r == ST_IDLE && op_valid && op_code == `OPC_CARRY_CLEAR) |=> !carry_flag)
    else $error("carry not cleared");
  a_error_hold: assert property (@(posedge core_clk) disable iff (!arst_n) // see (RULE12)
    (state_r == ST_CALC && bad_nxt) |=> (!result_write && invalid_digit_flag && $stable(carry_flag)))
    else $error("error case wrote result");
  a_add_latency: assert property (@(posedge core_clk) disable iff (!arst_n) // see (RULE1)
    (state_r == ST_IDLE && op_valid && is_add(op_code)) |=> busy ##1 done)
    else $error("add answer late");
  a_zero_match: assert property (@(posedge core_clk) disable iff (!arst_n) // see (RULE7)
    result_write |-> zero_result_flag == (result_lo == '0 && result_hi == '0))
    else $error("zero flag mismatch");
  a_single_high: assert property (@(posedge core_clk) disable iff (!arst_n) // see (RULE9)
    (result_write && !result_double) |-> result_hi == '0)
    else $error("single add wrote high word");
  a_digit_valid: assert property (@(posedge core_clk) disable iff (!arst_n) // see (RULE13)
    result_write |-> !has_bad_digit({result_hi, result_lo}, DIGITS_DOUBLE))
    else $error("result digit above nine");
  a_single_error: assert property (@(posedge core_clk) disable iff (!arst_n) // see (RULE5)
    (state_r == ST_CALC && !double_r && a_r[`DIGIT_W-1:0] > `DIGIT_MAX) |=> invalid_digit_flag)
    else $error("bad digit missed");
  a_double_error: assert property (@(posedge core_clk) disable iff (!arst_n) // see (RULE6)
    (state_r == ST_CALC && double_r && b_r[WIDE-1 -: `DIGIT_W] > `DIGIT_MAX) |=> invalid_digit_flag)
    else $error("high bad digit missed");
  a_carry_in: assert property (@(posedge core_clk) disable iff (!arst_n) // see (RULE3)
    (state_r == ST_CALC && !use_carry_r) |-> !chain[0])
    else $error("carry leaked into plain add");
endmodule

// File: hw/bcd_adder_defines.svh
// Purpose: constants for the decimal adder datapath
// Assumes: 16-bit controller words, 4-bit decimal digits
// Notes: operation codes are three-digit decimal codes held as hex digits
`ifndef BCD_ADDER_DEFINES_SVH
`define BCD_ADDER_DEFINES_SVH
`define OPC_ADD_SINGLE 12'h404
`define OPC_ADD_DOUBLE 12'h405
`define OPC_ADD_SINGLE_CI 12'h406
`define OPC_ADD_DOUBLE_CI 12'h407
`define OPC_CARRY_CLEAR 12'h041
`define OPC_W 12
`define WORD_W 16
`define DIGIT_W 4
`define DIGIT_MAX 4'h9
`define DIGIT_FIX 4'h6
`define FLAG_RESET 1'b0
`endif

// File: hw/bcd_adder_pkg.sv
// Purpose: types for the decimal adder datapath
// Assumes: defines header on the include path
// Notes: none
`include "bcd_adder_defines.svh"
package bcd_adder_pkg;
  typedef logic [`OPC_W-1:0] opcode_type;
  typedef logic [`WORD_W-1:0] word_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CALC = 2'b01,
    ST_DONE = 2'b10
  } state_type;
endpackage

// File: hw/bcd_digit_chain.sv
// Purpose: ripple chain of decimal digit adders
// Assumes: operands already checked for valid digits
// Notes: purely combinational
`timescale 1ns/1ps
`include "bcd_adder_defines.svh"
module bcd_digit_chain #(
  parameter int DIGITS = 8
) (
  input wire logic [DIGITS*`DIGIT_W-1:0] first_summand,
  input wire logic [DIGITS*`DIGIT_W-1:0] second_summand,
  input wire logic carry_in,
  output logic [DIGITS*`DIGIT_W-1:0] sum,
  output logic [DIGITS:0] carry_chain
);
  assign carry_chain[0] = carry_in;
  genvar g;
  generate
    for (g = 0; g < DIGITS; g++) begin : g_digit
      logic [`DIGIT_W:0] raw;
      logic over;
      assign raw = {1'b0, first_summand[g*`DIGIT_W +: `DIGIT_W]}
                 + {1'b0, second_summand[g*`DIGIT_W +: `DIGIT_W]}
                 + {{`DIGIT_W{1'b0}}, carry_chain[g]};
      // Sum above nine takes the decimal correction
      assign over = raw > {1'b0, `DIGIT_MAX}; // see (RULE13)
      assign sum[g*`DIGIT_W +: `DIGIT_W] = over ? raw[`DIGIT_W-1:0] + `DIGIT_FIX : raw[`DIGIT_W-1:0];
      assign carry_chain[g+1] = over; // see (RULE13)
    end
  endgenerate
endmodule

// File: verification/seq_model.sv
// Purpose: sequencer and destination word model
// Assumes: requests taken at the rising edge
// Notes: drives at the falling edge, operands flipped after done
`timescale 1ns/1ps
module seq_model (
  input wire logic core_clk,
  input wire logic done,
  input wire logic result_write,
  input wire logic result_double,
  input wire bcd_adder_pkg::word_type result_lo,
  input wire bcd_adder_pkg::word_type result_hi,
  output logic op_valid,
  output bcd_adder_pkg::opcode_type op_code,
  output bcd_adder_pkg::word_type a_lo,
  output bcd_adder_pkg::word_type a_hi,
  output bcd_adder_pkg::word_type b_lo,
  output bcd_adder_pkg::word_type b_hi
);
  import bcd_adder_pkg::*;
  word_type mem_lo = 16'h0000;
  word_type mem_hi = 16'h0000;
  int writes = 0;
  logic hung = 1'b0;
  initial begin
    {op_valid, op_code, a_lo, a_hi, b_lo, b_hi} = '0;
  end
  // Destination words
  always @(posedge core_clk) begin
    if (result_write === 1'b1) begin
      mem_lo <= result_lo;
      if (result_double === 1'b1) begin
        mem_hi <= result_hi;
      end
      writes <= writes + 1;
    end
  end
  task automatic issue(input logic cond, input opcode_type code, input logic [31:0] a, input logic [31:0] b,
                       input logic wait_done);
    int i;
    if (cond) begin
      @(negedge core_clk);
      op_valid = 1'b1;
      op_code = code;
      {a_hi, a_lo} = a;
      {b_hi, b_lo} = b;
      @(negedge core_clk);
      op_valid = 1'b0;
      for (i = 0; i < 8 && !(wait_done && done === 1'b1); i++) begin
        @(negedge core_clk);
      end
      hung = wait_done && i == 8;
      @(negedge core_clk);
      {a_hi, a_lo, b_hi, b_lo} = ~{a_hi, a_lo, b_hi, b_lo};
    end
  endtask
endmodule

// File: verification/bcd_adder_unit_bench.sv
// Purpose: self-checking bench for the decimal add unit
// Assumes: seq_model issues the requests
// Notes: expectations from a digit model in the bench
`timescale 1ns/1ps
`include "bcd_adder_defines.svh"
module bcd_adder_unit_bench;
  import bcd_adder_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic op_valid, busy, done, result_write, result_double;
  logic invalid_digit_flag, zero_result_flag, carry_flag;
  opcode_type op_code;
  word_type a_lo, a_hi, b_lo, b_hi, result_lo, result_hi;
  int error_cnt = 0;
  int cmp_count = 0;
  logic exp_cy = 1'b0;
  logic exp_z = 1'b0;
  logic exp_err = 1'b0;
  logic [31:0] exp_mem = 32'h0;
  always #12.5 core_clk = ~core_clk;
  bcd_adder_unit bcd_adder_unit_i (.core_clk(core_clk), .arst_n(arst_n), .op_valid(op_valid), .op_code(op_code),
    .first_summand_lo(a_lo), .first_summand_hi(a_hi), .second_summand_lo(b_lo), .second_summand_hi(b_hi),
    .busy(busy), .done(done), .result_write(result_write), .result_double(result_double),
    .result_lo(result_lo), .result_hi(result_hi), .invalid_digit_flag(invalid_digit_flag),
    .zero_result_flag(zero_result_flag), .carry_flag(carry_flag));
  seq_model seq_model_i (.core_clk(core_clk), .done(done), .result_write(result_write),
    .result_double(result_double), .result_lo(result_lo), .result_hi(result_hi), .op_valid(op_valid),
    .op_code(op_code), .a_lo(a_lo), .a_hi(a_hi), .b_lo(b_lo), .b_hi(b_hi));
  function automatic logic [32:0] dec_add(input logic [31:0] a, input logic [31:0] b, input logic ci, input int n);
    logic [32:0] r;
    logic [4:0] s;
    r = '0;
    r[32] = ci;
    for (int d = 0; d < n; d++) begin
      s = a[4*d +: 4] + b[4*d +: 4] + r[32];
      r[32] = s > 5'h09;
      r[4*d +: 4] = 4'(r[32] ? s - 5'h0A : s);
    end
    return r;
  endfunction
  function automatic logic bad_digit(input logic [31:0] x, input int n);
    logic f;
    f = 1'b0;
    for (int d = 0; d < n; d++) begin
      f = f | (x[4*d +: 4] > 4'h9);
    end
    return f;
  endfunction
  task automatic conclude();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic run(input opcode_type code, input logic [31:0] a, input logic [31:0] b, input logic cond);
    logic [32:0] r;
    int n;
    int w;
    n = code[0] ? 8 : 4;
    w = seq_model_i.writes;
    r = dec_add(a, b, code[1] & exp_cy, n);
    seq_model_i.issue(cond, code, code[0] ? a : {~a[15:0], a[15:0]}, code[0] ? b : {~b[15:0], b[15:0]}, 1'b1);
    if (seq_model_i.hung) begin
      error_cnt++;
      conclude();
    end
    if (cond && (bad_digit(a, n) || bad_digit(b, n))) begin
      exp_err = 1'b1;
    end else if (cond) begin
      exp_err = 1'b0;
      exp_cy = r[32];
      exp_z = r[31:0] == 32'h0;
      exp_mem = code[0] ? r[31:0] : {exp_mem[31:16], r[15:0]};
    end
    check(invalid_digit_flag, exp_err);
    check(carry_flag, exp_cy);
    check(zero_result_flag, exp_z);
    check({seq_model_i.mem_hi, seq_model_i.mem_lo}, exp_mem);
    check(32'(seq_model_i.writes - w), cond && !exp_err);
  endtask
  task automatic t_add();
    run(`OPC_ADD_SINGLE, 32'h1234, 32'h5678, 1'b1);
    run(`OPC_ADD_SINGLE, 32'h9999, 32'h0001, 1'b1);
    run(`OPC_ADD_SINGLE_CI, 32'h0000, 32'h0000, 1'b1);
    run(`OPC_ADD_SINGLE_CI, 32'h4995, 32'h5004, 1'b1);
    run(`OPC_ADD_DOUBLE, 32'h9999_9999, 32'h0000_0001, 1'b1);
    run(`OPC_ADD_DOUBLE_CI, 32'h1234_5678, 32'h8765_4320, 1'b1);
    run(`OPC_ADD_DOUBLE_CI, 32'h0000_9999, 32'h0000_0001, 1'b1);
  endtask
  task automatic t_clear();
    run(`OPC_ADD_SINGLE, 32'h5000, 32'h5000, 1'b1);
    seq_model_i.issue(1'b1, 12'h410, 32'h0, 32'h0, 1'b0);
    check(carry_flag, 1'b1);
    seq_model_i.issue(1'b1, `OPC_CARRY_CLEAR, 32'h0, 32'h0, 1'b0);
    exp_cy = 1'b0;
    check(carry_flag, exp_cy);
    run(`OPC_ADD_SINGLE_CI, 32'h0000, 32'h0000, 1'b1);
  endtask
  task automatic t_error();
    run(`OPC_ADD_SINGLE, 32'h9999, 32'h0001, 1'b1);
    run(`OPC_ADD_SINGLE, 32'h00A0, 32'h0001, 1'b1);
    run(`OPC_ADD_SINGLE_CI, 32'h0001, 32'h000F, 1'b1);
    run(`OPC_ADD_DOUBLE, 32'hB000_0000, 32'h0000_0000, 1'b1);
    run(`OPC_ADD_DOUBLE_CI, 32'h0000_0000, 32'h000C_0000, 1'b1);
    run(`OPC_ADD_SINGLE, 32'h000D, 32'h0001, 1'b1);
    run(`OPC_ADD_DOUBLE, 32'h0000_0000, 32'hE000_0000, 1'b1);
    run(`OPC_ADD_SINGLE, 32'h0001, 32'h0002, 1'b1);
    run(`OPC_ADD_DOUBLE, 32'h1111_1111, 32'h2222_2222, 1'b0);
  endtask
  initial begin
    repeat (8) @(negedge core_clk);
    arst_n = 1'b1;
    check({busy, done, result_write, result_double, invalid_digit_flag, zero_result_flag, carry_flag}, 32'h0);
    t_add();
    t_clear();
    t_error();
    conclude();
  end
endmodule
